// *** src/bvsel_pkg.sv ***
// Package with the map, field layout and defaults of the buck one operating-voltage register.
package bvsel_pkg;

    // Width of the register port address and data.
    localparam int BVSEL_ADDR_W = 8;
    localparam int BVSEL_DATA_W = 8;

    // Offset of the operating-voltage register.
    localparam logic [7:0] BVSEL_OP_OFFSET = 8'h04;

    // Field layout of the operating-voltage register.
    localparam int BVSEL_RSVD_BIT = 7;
    localparam int BVSEL_OUT_SEL_BIT = 6;
    localparam int BVSEL_CODE_MSB = 5;
    localparam int BVSEL_CODE_LSB = 0;
    localparam int BVSEL_CODE_W = 6;
    localparam int BVSEL_RANGE_W = 2;

    // Reset values; the code default is per variant and only a starting point.
    localparam logic [5:0] BVSEL_CODE_RESET = 6'h1c;
    localparam logic BVSEL_OUT_SEL_RESET = 1'b0;

    // Source of the converter output voltage.
    typedef enum logic {
        BVSEL_SRC_OPERATING,
        BVSEL_SRC_SCALING
    } bvsel_src_t;

endpackage

// *** src/bvsel_source_pick.sv ***
// Combinational choice of the register that sets the converter output voltage.
`timescale 1ns/1ps
`default_nettype none

module bvsel_source_pick
    import bvsel_pkg::*;
(
    // Control inputs.
    input wire logic output_register_select,
    input wire logic config_strap_pin_b,
    input wire logic buck_one_select_pin,
    // Chosen source.
    output var bvsel_pkg::bvsel_src_t source
);

    // Pick function kept separate so the top registers its result once.
    function automatic bvsel_src_t pick(input logic sel_bit, input logic strap_b,
                                        input logic pin);
        bvsel_src_t result;
        result = BVSEL_SRC_OPERATING;
        if (sel_bit)
        begin
            result = BVSEL_SRC_SCALING; // [R2]
        end
        else if (!strap_b)
        begin
            // Strap low hands the choice to the external pin. [R4]
            result = pin ? BVSEL_SRC_SCALING : BVSEL_SRC_OPERATING;
        end
        else
        begin
            result = BVSEL_SRC_OPERATING; // [R1]
        end
        return result;
    endfunction

    // Selection follows the inputs with no state of its own.
    always_comb
    begin
        source = pick(output_register_select, config_strap_pin_b, buck_one_select_pin);
    end

endmodule
`default_nettype wire

// *** src/bvsel_top.sv ***
// Operating-voltage register of the first step-down converter, with output source selection.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] With the select bit at 0 and the pin function off, the output voltage uses this register's code.
// [R2] With the select bit at 1, the output voltage uses the companion scaling register's code.
// [R3] Software keeps the select bit at 0 whenever the strap pin is low.
// [R4] With the strap low and the select bit at 0, the external select pin picks the source register.
// [R5] The chosen six-bit code is read through the two-bit span setting of the limit register.
// [R6] While the power request is low the voltage code is held at its default.
// [R7] Power-on reset restores the register to its defaults, the code default being a variant setting.
// [R8] Bit 7 reads as 0 and writes to it are ignored.
module bvsel_top
    import bvsel_pkg::*;
#(
    parameter logic [5:0] CODE_DEFAULT = BVSEL_CODE_RESET
)
(
    // Clock and power-on reset.
    input wire logic mclk,
    input wire logic rst,
    // Register port from the serial control interface.
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [bvsel_pkg::BVSEL_ADDR_W-1:0] reg_addr,
    input wire logic [bvsel_pkg::BVSEL_DATA_W-1:0] reg_wdata,
    output logic [bvsel_pkg::BVSEL_DATA_W-1:0] reg_rdata,
    output logic reg_rd_hit,
    // Device pins and companion register contents.
    input wire logic power_request,
    input wire logic config_strap_pin_b,
    input wire logic buck_one_select_pin,
    input wire logic [bvsel_pkg::BVSEL_CODE_W-1:0] buck_one_scaling_voltage,
    input wire logic [bvsel_pkg::BVSEL_RANGE_W-1:0] limit_range,
    // Converter voltage request and dropped-write status flag.
    output logic [bvsel_pkg::BVSEL_CODE_W-1:0] converter_code,
    output logic [bvsel_pkg::BVSEL_RANGE_W-1:0] converter_range,
    output logic converter_uses_scaling,
    output logic write_dropped
);

    import bvsel_pkg::*;

    // The scaling and limit registers live in neighbouring banks; this block sees
    // their contents only as inputs and never writes them.
    // The code-to-voltage table is applied downstream, so the span setting simply
    // travels beside the chosen code and both reach the converter in the same cycle.

    // Stored fields of the operating-voltage register.
    logic [BVSEL_CODE_W-1:0] code_reg;
    logic [BVSEL_CODE_W-1:0] code_next;
    logic out_sel_reg;

    // Register port outputs and converter outputs.
    logic [BVSEL_DATA_W-1:0] rdata_reg;
    logic rd_hit_reg;
    logic [BVSEL_CODE_W-1:0] conv_code_reg;
    logic [BVSEL_RANGE_W-1:0] conv_range_reg;
    logic uses_scaling_reg;
    logic dropped_reg;

    // Decoded access strobes and selection result.
    logic addr_hit;
    logic wr_hit;
    bvsel_src_t source;
    // Next values of the converter request.
    logic [BVSEL_CODE_W-1:0] conv_code_next;
    logic uses_scaling_next;

    // Address decode is shared by reads and writes.
    function automatic logic is_op_addr(input logic [BVSEL_ADDR_W-1:0] addr);
        return addr == BVSEL_OP_OFFSET;
    endfunction

    // Assemble the read view; bit 7 always reads as zero.
    function automatic logic [BVSEL_DATA_W-1:0] read_view(input logic sel_bit,
                                                          input logic [BVSEL_CODE_W-1:0] code);
        logic [BVSEL_DATA_W-1:0] view;
        view = 8'h00;
        view[BVSEL_OUT_SEL_BIT] = sel_bit;
        view[BVSEL_CODE_MSB:BVSEL_CODE_LSB] = code;
        view[BVSEL_RSVD_BIT] = 1'b0; // [R8]
        return view;
    endfunction

    // Strobes for this register only; other addresses belong to other banks.
    always_comb
    begin
        addr_hit = is_op_addr(reg_addr);
        wr_hit = reg_wr_en && addr_hit;
    end

    // Next voltage code.
    // The power request override sits above software writes, so a write made while
    // the request is low is lost rather than applied later when the request returns.
    always_comb
    begin
        code_next = code_reg;
        if (!power_request)
        begin
            code_next = CODE_DEFAULT; // [R6]
        end
        else if (wr_hit)
        begin
            code_next = reg_wdata[BVSEL_CODE_MSB:BVSEL_CODE_LSB];
        end
    end

    // Voltage code field.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            code_reg <= CODE_DEFAULT; // [R7]
        end
        else
        begin
            code_reg <= code_next;
        end
    end

    // Select bit; only the code follows the power request, this bit keeps its value.
    // Software is expected to leave it at 0 while the strap is low; the hardware
    // still honours a 1, which then overrides the external pin. [R3]
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            out_sel_reg <= BVSEL_OUT_SEL_RESET; // [R7]
        end
        else if (wr_hit)
        begin
            out_sel_reg <= reg_wdata[BVSEL_OUT_SEL_BIT]; // [R8]
        end
    end

    // Flags a code write that the low power request overrode, for one cycle.
    // Status only: nothing inside the block acts on it.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            dropped_reg <= 1'b0;
        end
        else
        begin
            dropped_reg <= wr_hit && !power_request; // [R6]
        end
    end

    // Read data is captured one cycle after the request; misses read as zero.
    // A read and a write in the same cycle return the contents from before the write.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdata_reg <= 8'h00;
            rd_hit_reg <= 1'b0;
        end
        else if (reg_rd_en)
        begin
            rdata_reg <= addr_hit ? read_view(out_sel_reg, code_reg) : 8'h00; // [R8]
            rd_hit_reg <= addr_hit;
        end
        else
        begin
            rd_hit_reg <= 1'b0;
        end
    end

    // Source choice between this register and the scaling register.
    bvsel_source_pick u_pick (
        .output_register_select(out_sel_reg),
        .config_strap_pin_b(config_strap_pin_b),
        .buck_one_select_pin(buck_one_select_pin),
        .source(source)
    );

    // Next converter request; the scaling register wins whenever the pick says so.
    always_comb
    begin
        conv_code_next = code_reg;
        uses_scaling_next = 1'b0;
        case (source)
            BVSEL_SRC_SCALING:
            begin
                conv_code_next = buck_one_scaling_voltage; // [R2]
                uses_scaling_next = 1'b1;
            end
            default:
            begin
                conv_code_next = code_reg; // [R1]
                uses_scaling_next = 1'b0;
            end
        endcase
    end

    // Converter request, registered so glitches on the pins never reach the loop.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            conv_code_reg <= CODE_DEFAULT; // [R7]
            conv_range_reg <= '0;
            uses_scaling_reg <= 1'b0;
        end
        else
        begin
            conv_code_reg <= conv_code_next;
            uses_scaling_reg <= uses_scaling_next;
            conv_range_reg <= limit_range; // [R5]
        end
    end

    // Outputs straight from flip-flops.
    assign reg_rdata = rdata_reg;
    assign reg_rd_hit = rd_hit_reg;
    assign converter_code = conv_code_reg;
    assign converter_range = conv_range_reg;
    assign converter_uses_scaling = uses_scaling_reg;
    assign write_dropped = dropped_reg;

endmodule
`default_nettype wire

// *** test/bvsel_top_chk.sv ***
// Checker of the operating-voltage register ports, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module bvsel_chk #(parameter logic [5:0] CODE_DEFAULT = 6'h1c)
(
    // Clock, reset and register port.
    input wire logic mclk, rst, reg_wr_en, reg_rd_en, reg_rd_hit,
    input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
    // Pins, companion register contents, converter request and drop flag.
    input wire logic power_request, config_strap_pin_b, buck_one_select_pin, write_dropped,
    input wire logic [5:0] buck_one_scaling_voltage, converter_code,
    input wire logic [1:0] limit_range, converter_range,
    input wire logic converter_uses_scaling
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Accesses that address this register.
    wire logic hit_rd = reg_rd_en && reg_addr == 8'h04;
    wire logic hit_wr = reg_wr_en && reg_addr == 8'h04;
    a_read_hit: assert property (hit_rd |=> reg_rd_hit)
        else $error("Read of the register gave no hit.");
    a_miss_zero: assert property (reg_rd_en && !hit_rd |=> !reg_rd_hit && reg_rdata == 8'h00)
        else $error("Unmapped read did not return zero.");
    a_rsvd_zero: assert property (reg_rd_hit |-> !reg_rdata[7])
        else $error("Reserved bit read as one.");
    a_rdata_hold: assert property (!reg_rd_en |=> $stable(reg_rdata))
        else $error("Read data changed without a read.");
    a_sel_scaling: assert property (hit_wr && reg_wdata[6] |=> ##1 converter_uses_scaling
        && converter_code == $past(buck_one_scaling_voltage)) else $error("Select bit ignored.");
    a_pin_choice: assert property (!config_strap_pin_b && buck_one_select_pin |=>
        converter_uses_scaling && converter_code == $past(buck_one_scaling_voltage))
        else $error("Select pin ignored.");
    a_range_copy: assert property (1'b1 |=> converter_range == $past(limit_range))
        else $error("Span setting not passed on.");
    a_drop_flag: assert property (hit_wr && !power_request |=> write_dropped)
        else $error("Dropped write not flagged.");
    a_pwr_default: assert property (!power_request ##1 (!power_request && hit_rd) |=>
        reg_rdata[5:0] == CODE_DEFAULT) else $error("Code not at default while power low.");
    // Main scenarios reached.
    c_dropped: cover property (write_dropped);
    c_sel_read: cover property (reg_rd_hit && reg_rdata[6]);
    c_scaling: cover property (converter_uses_scaling);
endmodule
bind bvsel_top bvsel_chk #(.CODE_DEFAULT(CODE_DEFAULT)) u_chk (.mclk(mclk), .rst(rst),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_rd_hit(reg_rd_hit),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .power_request(power_request), .config_strap_pin_b(config_strap_pin_b),
    .buck_one_select_pin(buck_one_select_pin), .write_dropped(write_dropped),
    .buck_one_scaling_voltage(buck_one_scaling_voltage), .converter_code(converter_code),
    .limit_range(limit_range), .converter_range(converter_range),
    .converter_uses_scaling(converter_uses_scaling));
`default_nettype wire

// *** test/bvsel_host.sv ***
// Host model that makes register requests on the serial-port side.
`timescale 1ns/1ps
`default_nettype none
module bvsel_host
(
    // Clock and read answer.
    input wire logic mclk,
    input wire logic reg_rd_hit,
    input wire logic [7:0] reg_rdata,
    // Request lines.
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // Idle request lines; released lines show the inverse so stale values never look live.
    initial
    begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One write, held across the taking edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr_en = 1'b1;
        @(negedge mclk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~v;
        // Idle cycle, so back-to-back calls never set a line twice in one time step.
        @(negedge mclk);
    endtask
    // One read; data and hit are valid just after the taking edge and are sampled at the next falling edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] v, output logic h);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        v = reg_rdata;
        h = reg_rd_hit;
        // Idle cycle, so back-to-back calls never set a line twice in one time step.
        @(negedge mclk);
    endtask
endmodule
`default_nettype wire

// *** test/tb_bvsel_top.sv ***
// Self-checking bench for the buck one operating-voltage register.
`timescale 1ns/1ps
`default_nettype none
module tb_bvsel_top;
    import bvsel_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, power_request = 1'b1, config_strap_pin_b = 1'b1;
    logic buck_one_select_pin = 1'b0, reg_wr_en, reg_rd_en, reg_rd_hit, uses, dropped, h;
    logic [5:0] scal = 6'h2a, code;
    logic [1:0] limit_range = 2'h2, range;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    int bad_count = 0, total_checks = 0;
    bvsel_top #(.CODE_DEFAULT(BVSEL_CODE_RESET)) u_dut (.mclk(mclk), .rst(rst),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit),
        .power_request(power_request), .config_strap_pin_b(config_strap_pin_b),
        .buck_one_select_pin(buck_one_select_pin), .buck_one_scaling_voltage(scal),
        .limit_range(limit_range), .converter_code(code), .converter_range(range),
        .converter_uses_scaling(uses), .write_dropped(dropped));
    bvsel_host u_host (.mclk(mclk), .reg_rd_hit(reg_rd_hit), .reg_rdata(reg_rdata),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // Clock of 25 ns period.
    initial
    begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Read and compare both the data and the hit flag.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        u_host.rd(a, d, h);
        chk(d, exp);
        chk({7'h00, h}, {7'h00, a == 8'h04});
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Main sequence; every step waits the fixed latency that the port contract gives.
    initial
    begin
        cyc(3);
        rst = 1'b0;
        rd(8'h04, {2'h0, BVSEL_CODE_RESET});
        rd(8'h05, 8'h00);
        u_host.wr(8'h04, 8'hff);
        rd(8'h04, 8'h7f);
        cyc(1);
        chk({1'b0, uses, code}, {2'h1, scal});
        u_host.wr(8'h04, 8'h05);
        cyc(1);
        chk({1'b0, uses, code}, 8'h05);
        chk({6'h00, range}, {6'h00, limit_range});
        // Strap low enables the pin; the select bit stays 0 meanwhile.
        config_strap_pin_b = 1'b0;
        buck_one_select_pin = 1'b1;
        cyc(1);
        chk({1'b0, uses, code}, {2'h1, scal});
        buck_one_select_pin = 1'b0;
        cyc(1);
        chk({1'b0, uses, code}, 8'h05);
        config_strap_pin_b = 1'b1;
        power_request = 1'b0;
        cyc(2);
        chk({1'b0, uses, code}, {2'h0, BVSEL_CODE_RESET});
        // The drop pulse stands one cycle, so it is looked at while the write ends.
        fork
            u_host.wr(8'h04, 8'h4a);
            begin
                cyc(1);
                chk({7'h00, dropped}, 8'h01);
            end
        join
        rd(8'h04, {2'h1, BVSEL_CODE_RESET});
        power_request = 1'b1;
        u_host.wr(8'h04, 8'h0b);
        rd(8'h04, 8'h0b);
        rst = 1'b1;
        cyc(1);
        rst = 1'b0;
        rd(8'h04, {2'h0, BVSEL_CODE_RESET});
        print_verdict();
    end
    // Guard against a hang.
    initial
    begin
        repeat (2000) @(posedge mclk);
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
